// ===== inc/reset_seq_pkg.sv
package reset_seq_pkg;

    // ========================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS      = 20;
    localparam int unsigned STRETCH_LOG2       = 17;
    localparam int unsigned STRETCH_CYCLES     = 1 << STRETCH_LOG2;
    localparam int unsigned PLL_SETTLE_US      = 100;
    localparam int unsigned PLL_SETTLE_CYCLES  = (PLL_SETTLE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned PCI_EXTRA_CLOCKS   = 255;
    localparam int unsigned SYNC_STAGES        = 2;

    // ========================================
    // Reset values
    localparam logic        SOFT_RESTART_RESET = 1'b0;

    // ========================================
    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_HELD    = 3'b001,
        ST_STRETCH = 3'b010,
        ST_RUN     = 3'b100
    } seq_state_t;

endpackage

// ===== core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
(
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic level_in,
    output logic      level_out
);
    logic stage1_reg;
    logic stage2_reg;

    // ========================================
    // Two-flop synchroniser, resets to asserted level
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
        end
        else
        begin
            stage1_reg <= level_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign level_out = stage2_reg;
endmodule

// ===== core/processor_reset_sequencer.sv
`timescale 1ns/1ns
module processor_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned STRETCH = STRETCH_CYCLES
)
(
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic hard_reset_in,
    input  wire logic pci_reset_in,
    input  wire logic soft_restart_set_in,
    input  wire logic soft_restart_clear_in,
    output logic      processor_hard_reset_out,
    output logic      processor_hard_reset_oe_out,
    output logic      soft_restart_out,
    output logic      stretch_active_out
);
    localparam int unsigned CW = $clog2(STRETCH + 1);

    logic            hard_sync;
    logic            pci_sync;
    logic            hold_now;
    seq_state_t      state_reg;
    seq_state_t      state_next;
    logic [CW-1:0]   count_reg;
    logic [CW-1:0]   count_next;
    logic            soft_reg;
    logic            soft_next;

    // ========================================
    // Pin synchronisers
    pin_sync u_hard_sync
    (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .level_in   (hard_reset_in),
        .level_out  (hard_sync)
    );

    pin_sync u_pci_sync
    (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .level_in   (pci_reset_in),
        .level_out  (pci_sync)
    );

    assign hold_now = hard_sync | pci_sync;

    // ========================================
    // Stretch sequencer
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            ST_HELD:
            begin
                count_next = '0;
                if (!hold_now)
                begin
                    state_next = ST_STRETCH;
                end
            end
            ST_STRETCH:
            begin
                if (hold_now)
                begin
                    state_next = ST_HELD;
                    count_next = '0;
                end
                else if (count_reg == CW'(STRETCH - 1))
                begin
                    state_next = ST_RUN;
                    count_next = '0;
                end
                else
                begin
                    count_next = count_reg + 1'b1;
                end
            end
            ST_RUN:
            begin
                if (hold_now)
                begin
                    state_next = ST_HELD;
                end
            end
            default:
            begin
                state_next = ST_HELD;
                count_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_HELD;
            count_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Open drain: value low, enable only while asserted
    assign processor_hard_reset_out    = 1'b0;
    assign processor_hard_reset_oe_out = (state_reg != ST_RUN);
    assign stretch_active_out          = (state_reg == ST_STRETCH);

    // ========================================
    // Soft restart
    always_comb
    begin
        soft_next = soft_reg;
        if (hard_sync)
        begin
            soft_next = 1'b0;
        end
        else if (soft_restart_set_in)
        begin
            soft_next = 1'b1;
        end
        else if (soft_restart_clear_in)
        begin
            soft_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            soft_reg <= SOFT_RESTART_RESET;
        end
        else
        begin
            soft_reg <= soft_next;
        end
    end

    assign soft_restart_out = soft_reg;

    // ========================================
    // Checks
    a_run_after_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_STRETCH && !hold_now && count_reg == CW'(STRETCH - 1))
        |=> processor_hard_reset_oe_out == 1'b0)
        else $error("output not released after stretch");

    a_hold_asserts: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hold_now |=> processor_hard_reset_oe_out)
        else $error("output not asserted during input reset");

    a_count_restart: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_STRETCH && hold_now) |=> (count_reg == '0 && state_reg == ST_HELD))
        else $error("count not restarted on reassertion");

    a_early_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $fell(processor_hard_reset_oe_out) |-> $past(count_reg) == CW'(STRETCH - 1))
        else $error("release before full count");

    a_drive_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        processor_hard_reset_oe_out |-> processor_hard_reset_out == 1'b0)
        else $error("open drain drives high");

    a_soft_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hard_sync |=> !soft_restart_out)
        else $error("soft restart not cleared by hard reset");

    a_soft_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (soft_restart_set_in && !hard_sync) |=> soft_restart_out)
        else $error("soft restart not set");

    a_soft_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!hard_sync && !soft_restart_set_in && !soft_restart_clear_in) |=> $stable(soft_restart_out))
        else $error("soft restart changed with no request");

    a_soft_sw_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (soft_restart_clear_in && !soft_restart_set_in) |=> !soft_restart_out)
        else $error("soft restart not cleared by software");

    // ========================================
    // Sequencer checks
    a_held_no_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_HELD) |-> count_reg == '0)
        else $error("count not zero while held");

    a_release_starts: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_HELD && !hold_now) |=> (stretch_active_out && count_reg == '0))
        else $error("stretch not started from zero after release");

    a_count_steps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_STRETCH && !hold_now && count_reg != CW'(STRETCH - 1))
        |=> (stretch_active_out && count_reg == CW'($past(count_reg) + 1'b1)))
        else $error("stretch count did not advance by one");

    a_run_stays: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_reg == ST_RUN && !hold_now) |=> !processor_hard_reset_oe_out)
        else $error("output asserted with no reset request");

    a_held_while_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hold_now |=> (!stretch_active_out && state_reg == ST_HELD))
        else $error("stretch running while reset held");

    a_stretch_bound: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stretch_active_out |-> count_reg <= CW'(STRETCH - 1))
        else $error("stretch count beyond its end");
endmodule

// ===== sim/reset_ctrl_model.sv
`timescale 1ns/1ns
// ========================================
// System reset controller and pin pull-up
module reset_ctrl_model
#(
    parameter int unsigned HOLD = 12
)
(
    input  wire logic clk_sys_in,
    input  wire logic req_in,
    input  wire logic soft_restart_in,
    input  wire logic pin_oe_in,
    output logic      hard_reset_out,
    output logic      cpu_reset_n_out
);
    int unsigned hold_reg = 0;
    always_ff @(posedge clk_sys_in)
    begin
        if (req_in || soft_restart_in) // Debounced latch
            hold_reg <= HOLD; // Minimum hold
        else if (hold_reg != 0)
            hold_reg <= hold_reg - 1;
    end
    assign hard_reset_out  = (hold_reg != 0);
    assign cpu_reset_n_out = pin_oe_in ? 1'b0 : 1'b1; // Pull-up
endmodule

// ===== sim/processor_reset_sequencer_test.sv
`timescale 1ns/1ns
// ========================================
// Bench top
module processor_reset_sequencer_test;
    import reset_seq_pkg::*;
    localparam int unsigned ST = 8;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic req = 1'b1;
    logic pci = 1'b0;
    logic s_set = 1'b0;
    logic s_clr = 1'b0;
    logic hr, pin, oe, sr, act, cpu_n;
    int   bad_count = 0;
    int   checks = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    processor_reset_sequencer #(.STRETCH(ST)) u_processor_reset_sequencer
    (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hard_reset_in(hr), .pci_reset_in(pci),
     .soft_restart_set_in(s_set), .soft_restart_clear_in(s_clr),
     .processor_hard_reset_out(pin), .processor_hard_reset_oe_out(oe),
     .soft_restart_out(sr), .stretch_active_out(act));
    reset_ctrl_model u_reset_ctrl_model
    (.clk_sys_in(clk_sys_in), .req_in(req), .soft_restart_in(sr), .pin_oe_in(oe),
     .hard_reset_out(hr), .cpu_reset_n_out(cpu_n));
    function automatic logic [31:0] exp_len(input int unsigned s);
        return s;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_act(input logic v);
        int n;
        n = 0;
        while (act !== v)
        begin
            @(negedge clk_sys_in);
            n++;
            if (n > 400)
            begin
                bad_count++;
                tally_and_finish;
            end
        end
    endtask
    task automatic stretch_len;
        int c;
        c = 0;
        wait_act(1'b1);
        while (act === 1'b1 && c < 400)
        begin
            c++;
            @(negedge clk_sys_in);
        end
        chk("stretch", c, exp_len(ST));
        chk("oe", oe, 1'b0);
        chk("pin", cpu_n, 1'b1);
        chk("out", pin, 1'b0);
    endtask
    initial
    begin
        void'($urandom(32'h8740AD17));
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        s_set <= 1'b1;
        @(posedge clk_sys_in);
        s_set <= 1'b0;
        @(negedge clk_sys_in);
        chk("soft", sr, 1'b0);
        chk("pin", cpu_n, 1'b0);
        @(posedge clk_sys_in);
        req <= 1'b0;
        stretch_len;
        repeat (4)
        begin
            @(posedge clk_sys_in);
            req <= 1'b1;
            @(posedge clk_sys_in);
            req <= 1'b0;
            wait_act(1'b1);
            repeat ($urandom_range(3)) @(negedge clk_sys_in);
            @(posedge clk_sys_in);
            req <= 1'b1;
            @(posedge clk_sys_in);
            req <= 1'b0;
            wait_act(1'b0);
            chk("oe", oe, 1'b1);
            stretch_len;
        end
        @(posedge clk_sys_in);
        pci <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("oe", oe, 1'b1);
        @(posedge clk_sys_in);
        pci <= 1'b0;
        stretch_len;
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("rst oe", oe, 1'b1);
        chk("rst act", act, 1'b0);
        chk("rst soft", sr, 1'b0);
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        stretch_len;
        @(posedge clk_sys_in);
        s_set <= 1'b1;
        @(posedge clk_sys_in);
        s_set <= 1'b0;
        s_clr <= 1'b1;
        @(negedge clk_sys_in);
        chk("soft set", sr, 1'b1);
        @(posedge clk_sys_in);
        s_clr <= 1'b0;
        @(negedge clk_sys_in);
        chk("soft clr", sr, 1'b0);
        stretch_len;
        @(posedge clk_sys_in);
        s_set <= 1'b1;
        s_clr <= 1'b1;
        @(posedge clk_sys_in);
        s_set <= 1'b0;
        s_clr <= 1'b0;
        @(negedge clk_sys_in);
        chk("soft", sr, 1'b1);
        repeat (5) @(negedge clk_sys_in);
        chk("soft", sr, 1'b0);
        chk("oe", oe, 1'b1);
        stretch_len;
        tally_and_finish;
    end
endmodule
